// ---- include/aphp_params.svh ----
/*
 Timing counts, field positions and reset values for the parallel host port.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef APHP_PARAMS_SVH
`define APHP_PARAMS_SVH

`define APHP_DATA_W 12
`define APHP_ADDR_LSB 10
`define APHP_ADDR_MSB 11
`define APHP_FIELD_W 10
`define APHP_CR0_RESET 10'h000
`define APHP_CR1_RESET 10'h000
`define APHP_CR0_EXTREF_BIT 0
`define APHP_CR1_WRONLY_BIT 0
`define APHP_CR1_DAV_HIGH_BIT 1
`define APHP_CR1_DAV_PULSE_BIT 2
`define APHP_CR1_FIFO_RST_BIT 3
`define APHP_RA_CR0 2'h0
`define APHP_RA_CR1 2'h1
`define APHP_FIFO_DEPTH 16
`define APHP_DAV_PULSE_NS 50
`define APHP_CLK_PERIOD_NS 25
`define APHP_DAV_PULSE_CYC ((`APHP_DAV_PULSE_NS + `APHP_CLK_PERIOD_NS - 1) / `APHP_CLK_PERIOD_NS)

`endif

// ---- include/aphp_pkg.sv ----
/*
 Types shared by the parallel host port design files.
 Assumes the params header sits on the include path.
*/
`include "aphp_params.svh"

package aphp_pkg;
	typedef logic [`APHP_DATA_W-1:0] aphp_word_type;

	typedef struct packed {
		logic cs_low_n;
		logic cs_high;
		logic wr_rw;
		logic rd_n;
	} aphp_strobe_type;

	typedef struct packed {
		logic ext_ref;
		logic write_only;
		logic dav_active_high;
		logic dav_pulse;
	} aphp_cfg_type;

	typedef enum logic [3:0] {
		APHP_IDLE = 4'b0001,
		APHP_READ = 4'b0010,
		APHP_WRITE = 4'b0100,
		APHP_WAIT = 4'b1000
	} aphp_state_type;
endpackage

// ---- rtl/aphp_sync.sv ----
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the inputs are asynchronous to sys_clk_i.
*/
`timescale 1ns/1ps

module aphp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Data
	input wire logic [WIDTH-1:0] async_i,
	input wire logic [WIDTH-1:0] reset_val_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	initial begin
		if (WIDTH < 1) $error("aphp_sync: WIDTH must be at least 1");
	end

	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	// Reset value is a tied constant from the instantiating module
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			meta_q <= reset_val_i;
			sync_q <= reset_val_i;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;
endmodule

// ---- rtl/aphp_host_port.sv ----
/*
 Parallel host port of a dual-input sampling converter: tristate data bus,
 selectable strobe scheme, two control registers, sample FIFO with overflow
 flag and a data-available output.
 Assumes strobes and data pins are asynchronous and held stable for several
 sys_clk_i periods; conversion results arrive as one-cycle pulses on sys_clk_i.
*/
`timescale 1ns/1ps
`include "aphp_params.svh"

module aphp_host_port #(
	parameter int DEPTH = `APHP_FIFO_DEPTH,
	parameter int PULSE_CYC = `APHP_DAV_PULSE_CYC,
	parameter int DAV_LEVEL = 1
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Host pins
	input wire aphp_pkg::aphp_strobe_type strobe_i,
	input wire aphp_pkg::aphp_word_type host_data_bus_i,
	output aphp_pkg::aphp_word_type host_data_bus_o,
	output logic host_data_bus_oe_n_o,
	// Converter side
	input wire logic sample_valid_i,
	input wire aphp_pkg::aphp_word_type sample_i,
	// Status and configuration
	output logic fifo_overflow_flag_o,
	output logic sample_ready_out_o,
	output logic ext_ref_sel_o,
	output logic [`APHP_FIELD_W-1:0] ctrl_reg0_o,
	output logic [`APHP_FIELD_W-1:0] ctrl_reg1_o
);
	import aphp_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("DEPTH must be a power of two, at least 2");
		if (PULSE_CYC < 1 || PULSE_CYC > 255) $error("PULSE_CYC must be 1 to 255");
		if (DAV_LEVEL < 1 || DAV_LEVEL > DEPTH) $error("DAV_LEVEL must be 1 to DEPTH");
	end

	// Synchronised pins
	aphp_strobe_type strb_s;
	aphp_word_type din_s;

	aphp_sync #(.WIDTH(4)) u_sync_strobe (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.async_i(strobe_i),
		.reset_val_i(4'b1011),
		.sync_o(strb_s)
	);

	aphp_sync #(.WIDTH(`APHP_DATA_W)) u_sync_data (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.async_i(host_data_bus_i),
		.reset_val_i(12'h000),
		.sync_o(din_s)
	);

	// Control registers
	logic [`APHP_FIELD_W-1:0] cr0_q, cr0_d, cr1_q, cr1_d;
	logic write_only;
	logic sel, rd_req, wr_req;
	aphp_state_type state_q, state_d;

	assign write_only = cr1_q[`APHP_CR1_WRONLY_BIT];
	assign sel = !strb_s.cs_low_n && strb_s.cs_high;

	// Both strobe schemes decoded from the current mode
	always_comb begin
		if (write_only) begin
			wr_req = sel && !strb_s.wr_rw;
			rd_req = sel && !strb_s.rd_n && strb_s.wr_rw;
		end else begin
			// Read strobe ignored in read-write mode; low R/W means write
			wr_req = sel && !strb_s.wr_rw;
			rd_req = sel && strb_s.wr_rw;
		end
	end

	// FIFO state
	aphp_word_type mem_q [DEPTH];
	logic [PTR_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic ovf_q, ovf_d;
	logic fifo_rst, pop, push;
	aphp_word_type dout_q, dout_d;
	logic oe_n_q, oe_n_d;

	assign fifo_rst = cr1_q[`APHP_CR1_FIFO_RST_BIT];

	// Access sequencer: one register update or FIFO pop per strobe
	always_comb begin
		state_d = state_q;
		cr0_d = cr0_q;
		cr1_d = cr1_q;
		pop = 1'b0;
		dout_d = dout_q;
		oe_n_d = 1'b1;
		// FIFO reset bit self-clears after one cycle
		cr1_d[`APHP_CR1_FIFO_RST_BIT] = 1'b0;
		case (state_q)
			APHP_IDLE: begin
				if (wr_req) begin
					state_d = APHP_WRITE;
				end else if (rd_req) begin
					state_d = APHP_READ;
					pop = (cnt_q != '0);
					dout_d = (cnt_q != '0) ? mem_q[rptr_q] : '0;
				end
			end
			APHP_WRITE: begin
				// Data sampled a cycle late to let the bus settle
				if (din_s[`APHP_ADDR_MSB:`APHP_ADDR_LSB] == `APHP_RA_CR0) begin
					cr0_d = din_s[`APHP_FIELD_W-1:0];
				end else if (din_s[`APHP_ADDR_MSB:`APHP_ADDR_LSB] == `APHP_RA_CR1) begin
					cr1_d = din_s[`APHP_FIELD_W-1:0];
				end
				state_d = APHP_WAIT;
			end
			APHP_READ: begin
				oe_n_d = !rd_req;
				if (!rd_req) state_d = APHP_IDLE;
			end
			APHP_WAIT: begin
				if (!wr_req) state_d = APHP_IDLE;
			end
			default: state_d = APHP_IDLE;
		endcase
		if (state_q == APHP_IDLE && rd_req) oe_n_d = 1'b0;
	end

	// FIFO next state; overflow set wins over FIFO reset clear
	// A pop frees a slot in the same cycle, so a full FIFO still takes a sample then
	always_comb begin
		push = sample_valid_i && (cnt_q != FULL || pop);
		wptr_d = wptr_q + PTR_W'(push);
		rptr_d = rptr_q + PTR_W'(pop);
		cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop);
		ovf_d = ovf_q;
		if (fifo_rst) begin
			wptr_d = '0;
			rptr_d = '0;
			cnt_d = '0;
			ovf_d = 1'b0;
		end
		if (sample_valid_i && cnt_q == FULL && !pop) ovf_d = 1'b1;
	end

	// Data-available: level at or above threshold, or a pulse on crossing it
	logic above, above_q, above_d;
	logic [7:0] pcnt_q, pcnt_d;
	logic dav_q, dav_d;

	always_comb begin
		above = cnt_q >= CNT_W'(DAV_LEVEL);
		above_d = above;
		pcnt_d = (pcnt_q != 8'h00) ? pcnt_q - 8'h01 : 8'h00;
		if (above && !above_q) pcnt_d = 8'(PULSE_CYC);
		// XNOR with the polarity bit inverts the pin when active low is chosen
		dav_d = (cr1_q[`APHP_CR1_DAV_PULSE_BIT] ? (pcnt_d != 8'h00) : above)
			~^ cr1_q[`APHP_CR1_DAV_HIGH_BIT];
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_q <= APHP_IDLE;
			cr0_q <= `APHP_CR0_RESET;
			cr1_q <= `APHP_CR1_RESET;
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
			ovf_q <= 1'b0;
			dout_q <= '0;
			oe_n_q <= 1'b1;
			above_q <= 1'b0;
			pcnt_q <= 8'h00;
			// Inactive level of the default active-low polarity, so no false interrupt
			dav_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cr0_q <= cr0_d;
			cr1_q <= cr1_d;
			wptr_q <= wptr_d;
			rptr_q <= rptr_d;
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
			dout_q <= dout_d;
			oe_n_q <= oe_n_d;
			above_q <= above_d;
			pcnt_q <= pcnt_d;
			dav_q <= dav_d;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (push) mem_q[wptr_q] <= sample_i;
	end

	// Outputs; bit 0 of the bus is the least significant sample bit
	assign host_data_bus_o = dout_q;
	assign host_data_bus_oe_n_o = oe_n_q;
	assign fifo_overflow_flag_o = ovf_q;
	assign sample_ready_out_o = dav_q;
	assign ext_ref_sel_o = cr0_q[`APHP_CR0_EXTREF_BIT];
	assign ctrl_reg0_o = cr0_q;
	assign ctrl_reg1_o = cr1_q;

	chk_ovf_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		ovf_q && !fifo_rst |=> ovf_q) else $error("overflow flag dropped without clear");
	chk_ovf_set: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		sample_valid_i && cnt_q == FULL && !pop |=> ovf_q) else $error("overflow not flagged");
	chk_ovf_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$fell(ovf_q) |-> $past(fifo_rst) || $past(reset_i)) else $error("overflow cleared without FIFO reset");
	chk_bus_drive: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!oe_n_q |-> $past(rd_req)) else $error("bus driven outside read");
	chk_sel_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!sel && state_q == APHP_IDLE |=> state_q == APHP_IDLE && oe_n_q) else $error("access while deselected");
	chk_rd_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!write_only && sel && strb_s.wr_rw && state_q == APHP_IDLE |=> state_q == APHP_READ)
		else $error("read strobe gated a read in read-write mode");
	chk_wr_cr0: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_q == APHP_WRITE && din_s[11:10] == 2'h0 |=> cr0_q == $past(din_s[9:0]))
		else $error("control register 0 not written");
	chk_write_len: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_q == APHP_IDLE && wr_req |=> state_q == APHP_WRITE ##1 state_q == APHP_WAIT)
		else $error("write sequence broken");
	chk_ref_sel: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		state_q == APHP_WRITE && din_s[11:10] == 2'h0 |=> ext_ref_sel_o == $past(din_s[0]))
		else $error("reference select mismatch");
	chk_reset_def: assert property (@(posedge sys_clk_i)
		reset_i |=> cr0_q == 10'h000 && cr1_q == 10'h000) else $error("defaults not loaded");
	chk_dav_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!cr1_q[2] |=> sample_ready_out_o == (($past(cnt_q) >= CNT_W'(DAV_LEVEL)) ~^ $past(cr1_q[1])))
		else $error("data-available level wrong");
endmodule

// ---- test/aphp_host_model.sv ----
/*
 Behavioural host processor on the parallel port: strobes, data and reads.
 Assumes the bench calls its tasks and wires the resolved bus to the device.
*/
`timescale 1ns/1ps

module aphp_host_model (
	// Clock
	input wire logic sys_clk_i,
	// Host pins
	output aphp_pkg::aphp_strobe_type strobe_o,
	output aphp_pkg::aphp_word_type bus_o,
	// Device drive
	input wire aphp_pkg::aphp_word_type dev_data_i,
	input wire logic dev_oe_n_i
);
	import aphp_pkg::*;
	logic drv = 1'b0;
	aphp_word_type hv = 12'h000;
	aphp_word_type last_q = 12'h000;
	// Deselected and read-write line high
	initial strobe_o = 4'hb;
	// No pull on the bus: a floating line shows the inverse of its last level
	assign bus_o = drv ? hv : (!dev_oe_n_i ? dev_data_i : ~last_q);
	always @(posedge sys_clk_i) if (drv || !dev_oe_n_i) last_q <= bus_o;

	task automatic wr(input logic [1:0] a, input logic [9:0] f, input logic sel);
		@(negedge sys_clk_i);
		hv = {a, f};
		drv = 1'b1;
		strobe_o = {1'b0, sel, 1'b0, 1'b1};
		repeat (6) @(negedge sys_clk_i);
		// Drop select in the same step that raises the line, so no read is seen
		strobe_o = 4'hb;
		@(negedge sys_clk_i);
		drv = 1'b0;
		repeat (4) @(negedge sys_clk_i);
	endtask

	task automatic rd(input logic rdn, output aphp_word_type d, output logic seen);
		seen = 1'b0;
		d = 12'h000;
		@(negedge sys_clk_i);
		strobe_o = {1'b0, 1'b1, 1'b1, rdn};
		for (int i = 0; i < 10 && !seen; i++) begin
			@(negedge sys_clk_i);
			if (dev_oe_n_i === 1'b0) begin
				seen = 1'b1;
				d = dev_data_i;
			end
		end
		strobe_o = 4'hb;
		repeat (6) @(negedge sys_clk_i);
	endtask
endmodule

// ---- test/tb.sv ----
/*
 Self-checking bench for the parallel host port.
 Assumes the host model drives the strobes and the bus at falling edges.
*/
`timescale 1ns/1ps
`include "aphp_params.svh"

module tb;
	import aphp_pkg::*;
	localparam int DEPTH = 4;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic sample_valid_i = 1'b0;
	aphp_word_type sample_i = 12'h000;
	aphp_word_type bus_in, dout, d;
	aphp_word_type q[$];
	aphp_strobe_type strobe;
	logic oe_n, ovf, rdy, xref, seen;
	logic [9:0] cr0, cr1, f;
	int err_total = 0;
	int n_checks = 0;
	int n;

	initial forever #12.5 sys_clk_i = ~sys_clk_i;

	aphp_host_model h (.sys_clk_i(sys_clk_i), .strobe_o(strobe), .bus_o(bus_in), .dev_data_i(dout),
		.dev_oe_n_i(oe_n));
	aphp_host_port #(.DEPTH(DEPTH)) dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .strobe_i(strobe),
		.host_data_bus_i(bus_in), .host_data_bus_o(dout), .host_data_bus_oe_n_o(oe_n),
		.sample_valid_i(sample_valid_i), .sample_i(sample_i), .fifo_overflow_flag_o(ovf),
		.sample_ready_out_o(rdy), .ext_ref_sel_o(xref), .ctrl_reg0_o(cr0), .ctrl_reg1_o(cr1));

	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic push(input aphp_word_type v);
		@(negedge sys_clk_i);
		sample_valid_i = 1'b1;
		sample_i = v;
		q.push_back(v);
		@(negedge sys_clk_i);
		sample_valid_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
	endtask

	// Read in read-write or write-only mode and compare against the queue
	task automatic rdx(input logic rdn, input logic exp_seen);
		h.rd(rdn, d, seen);
		chk({11'h000, seen}, {11'h000, exp_seen}, "read answered");
		if (exp_seen) chk(d, (q.size() > 0) ? q.pop_front() : 12'h000, "read data");
		chk({11'h000, oe_n}, 12'h001, "bus released");
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		void'($urandom(14563));
		repeat (8) @(negedge sys_clk_i);
		reset_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		chk({ovf, oe_n, cr0}, {2'b01, 10'h000}, "after reset");
		for (int i = 0; i < 4; i++) begin
			f = 10'($urandom);
			h.wr(2'h0, f, 1'b1);
			chk({xref, cr0}, {f[0], f}, "cr0 write");
		end
		h.wr(2'h1, 10'h002, 1'b1);
		chk(cr1, 10'h002, "cr1 write");
		h.wr(2'h2, 10'h3ff, 1'b1);
		h.wr(2'h3, 10'h3ff, 1'b1);
		h.wr(2'h1, 10'h3f1, 1'b0);
		chk({cr1, cr0}, {10'h002, f}, "ignored writes");
		for (int i = 0; i < DEPTH; i++) push(12'($urandom));
		chk(rdy, 1'b1, "ready high");
		for (int i = 0; i <= DEPTH; i++) rdx(1'b1, 1'b1);
		chk(rdy, 1'b0, "ready idle");
		h.wr(2'h1, 10'h000, 1'b1);
		chk(rdy, 1'b1, "low idle");
		push(12'h800);
		chk(rdy, 1'b0, "low ready");
		rdx(1'b1, 1'b1);
		for (int i = 0; i <= DEPTH; i++) push(12'($urandom));
		chk(ovf, 1'b1, "overflow set");
		repeat (20) @(negedge sys_clk_i);
		rdx(1'b1, 1'b1);
		chk(ovf, 1'b1, "overflow sticky");
		h.wr(2'h1, 10'h008, 1'b1);
		chk(ovf, 1'b0, "fifo reset");
		q.delete();
		rdx(1'b1, 1'b1);
		h.wr(2'h1, 10'h001, 1'b1);
		chk(cr1[0], 1'b1, "write only");
		push(12'h5a3);
		rdx(1'b1, 1'b0);
		rdx(1'b0, 1'b1);
		// Pulse mode, active high: one word raises a pulse of the configured length
		h.wr(2'h1, 10'h006, 1'b1);
		n = 0;
		@(negedge sys_clk_i);
		sample_valid_i = 1'b1;
		sample_i = 12'h3c5;
		q.push_back(12'h3c5);
		@(negedge sys_clk_i);
		sample_valid_i = 1'b0;
		repeat (6) begin
			if (rdy === 1'b1) n++;
			@(negedge sys_clk_i);
		end
		chk(24'(n), 24'(`APHP_DAV_PULSE_CYC), "pulse length");
		rdx(1'b1, 1'b1);
		@(negedge sys_clk_i);
		reset_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		reset_i = 1'b0;
		repeat (3) @(negedge sys_clk_i);
		chk({rdy, oe_n, ovf, cr1, cr0}, {3'b110, 20'h00000}, "second reset");
		finish_test();
	end
endmodule
